//--- design/cop_regs.svh
// register offset, layout masks, reset values and restore constants of the options register
`ifndef COP_REGS_SVH
`define COP_REGS_SVH
`define COP_CMD_OPTIONS 8'hE5
`define COP_OPT_RESET 16'h1184
`define COP_OPT_FIXED_MASK 16'h9400
`define COP_OPT_FIXED_VAL 16'h1000
`define COP_OPT_VOLATILE_MASK 16'h0018
`define COP_MLO_RESTORE_0 16'hFFF7
`define COP_MLO_RESTORE_1 16'hFFF1
`define COP_MHI_RESTORE_0 16'h0009
`define COP_MHI_RESTORE_1 16'h000F
`endif

//--- design/cop_pkg.sv
// types of the converter options register block
package cop_pkg;
   typedef struct packed {
      logic rsvd15;
      logic margin_up_restore_sel;
      logic margin_down_restore_sel;
      logic rsvd12;
      logic restore_vout_on_shutdown;
      logic rsvd10;
      logic [1:0] output_sense_divider_select;
      logic alert_auto_mask_on;
      logic [1:0] sample_average_depth;
      logic write_check_override;
      logic vout_only_fast_mode;
      logic monitor_converter_on;
      logic reset_out_select;
      logic neg_current_limit_off;
   } cop_opt_t;
   typedef enum logic [1:0] {COP_CH_VOUT, COP_CH_IOUT, COP_CH_TEMP} cop_chan_t;
   typedef struct packed {
      cop_chan_t chan;
      logic [11:0] data;
   } cop_sample_t;
endpackage

//--- design/cop_options.sv
// converter options register with the logic that its fields steer
// What this block does
// R1 - register at E5h, stored on store-all
// R2 - bit 0 set stops negative limit
// R3 - pin shows power good or reset
// R4 - monitor converter runs only when enabled
// R5 - disabled monitor freezes readback values
// R6 - fast mode measures output voltage only
// R7 - fast mode and override never stored
// R8 - fast mode change clears the partial voltage average
// R9 - override accepts out-of-range writes
// R10 - override writes raise no invalid flag
// R11 - averaging code 16, bypass, 8, 32
// R12 - same averaging for all readbacks
// R13 - auto mask set faults after alert response
// R14 - without auto, faults realert at once
// R15 - divider forced or follows loop scale
// R16 - shutdown events restore output voltage
// R17 - margin down restore fff7h or fff1h
// R18 - margin up restore 0009h or 000fh
// R19 - reserved bits read fixed, ignore writes
// R20 - load from storage, volatile bits cleared
`timescale 1ns/1ns
`include "cop_regs.svh"
module cop_options #(
   parameter int NFAULT = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // command port
   input wire logic [7:0] cmd_code,
   input wire logic cmd_wr,
   input wire logic [15:0] cmd_wdata,
   output logic [15:0] cmd_rdata,
   output logic cmd_hit,
   // nonvolatile storage
   input wire logic [15:0] nvm_data,
   input wire logic store_all,
   output logic nvm_wr,
   output logic [15:0] nvm_wdata,
   // monitor converter
   input wire logic sample_valid,
   input wire cop_pkg::cop_sample_t sample_in,
   output logic adc_run,
   output cop_pkg::cop_chan_t adc_chan,
   output logic [11:0] vout_rb,
   output logic [11:0] iout_rb,
   output logic [11:0] temp_rb,
   // protection and pin
   input wire logic neg_limit_trip,
   output logic neg_limit_act,
   input wire logic power_good_flag,
   input wire logic reset_req,
   output logic shared_status_pin,
   // write checks
   input wire logic chk_wr,
   input wire logic chk_bad,
   output logic chk_accept,
   output logic invalid_write_flag,
   // alert masking
   input wire logic [NFAULT-1:0] fault_src,
   input wire logic ara_done,
   input wire logic host_mask_wr,
   input wire logic [NFAULT-1:0] host_mask_data,
   output logic [NFAULT-1:0] fault_mask,
   output logic alert,
   // output voltage and margins
   input wire logic [1:0] loop_scale,
   output logic [1:0] sense_div,
   input wire logic shutdown_evt,
   output logic vout_restore,
   output logic [15:0] margin_down_restore,
   output logic [15:0] margin_up_restore
);
   import cop_pkg::*;

   // ******************************
   // options register
   // ******************************
   cop_opt_t opt_r, opt_nxt;
   logic load_pend_r;
   logic [15:0] nvm_clean;
   wire sel_hit = (cmd_code == `COP_CMD_OPTIONS); // [R1]
   // fixed bits forced, volatile bits cleared on load
   assign nvm_clean = ((nvm_data & ~`COP_OPT_FIXED_MASK & ~`COP_OPT_VOLATILE_MASK)
                      | `COP_OPT_FIXED_VAL); // [R20] [R19]
   assign opt_nxt = load_pend_r ? cop_opt_t'(nvm_clean) :
                    (cmd_wr && sel_hit) ? cop_opt_t'((cmd_wdata & ~`COP_OPT_FIXED_MASK)
                    | `COP_OPT_FIXED_VAL) : opt_r; // [R19]
   // reset takes the constant default, storage loads one edge later
   always_ff @(posedge clk) begin
      if (rst) begin
         opt_r <= cop_opt_t'(`COP_OPT_RESET);
         load_pend_r <= 1'b1;
      end else begin
         opt_r <= opt_nxt; // [R20]
         load_pend_r <= 1'b0;
      end
   end
   assign cmd_hit = sel_hit;
   assign cmd_rdata = sel_hit ? 16'(opt_r) : 16'h0000;

   // store-all copies non-volatile bits out
   always_ff @(posedge clk) begin
      if (rst) begin
         nvm_wr <= 1'b0;
         nvm_wdata <= 16'h0000;
      end else begin
         nvm_wr <= store_all; // [R1]
         if (store_all) begin
            nvm_wdata <= 16'(opt_r) & ~`COP_OPT_VOLATILE_MASK; // [R7]
         end
      end
   end

   // ******************************
   // protection, pin, divider, restores
   // ******************************
   assign neg_limit_act = neg_limit_trip & ~opt_r.neg_current_limit_off; // [R2]
   assign shared_status_pin = opt_r.reset_out_select ? ~reset_req : power_good_flag; // [R3]
   assign sense_div = (opt_r.output_sense_divider_select != 2'h0) ?
                      opt_r.output_sense_divider_select : 2'h3 - loop_scale; // [R15]
   assign vout_restore = shutdown_evt & opt_r.restore_vout_on_shutdown; // [R16]
   assign margin_down_restore = opt_r.margin_down_restore_sel ? `COP_MLO_RESTORE_1
                                : `COP_MLO_RESTORE_0; // [R17]
   assign margin_up_restore = opt_r.margin_up_restore_sel ? `COP_MHI_RESTORE_1
                              : `COP_MHI_RESTORE_0; // [R18]

   // ******************************
   // write checks
   // ******************************
   assign chk_accept = opt_r.write_check_override; // [R9]
   assign invalid_write_flag = chk_wr & chk_bad & ~opt_r.write_check_override; // [R10]

   // ******************************
   // alert masking
   // ******************************
   logic [NFAULT-1:0] mask_r;
   wire [NFAULT-1:0] mask_base = host_mask_wr ? host_mask_data : mask_r; // [R14]
   wire [NFAULT-1:0] mask_nxt = mask_base | ((ara_done && opt_r.alert_auto_mask_on) ?
                                fault_src : '0); // [R13]
   always_ff @(posedge clk) begin
      if (rst) begin
         mask_r <= '0;
      end else begin
         mask_r <= mask_nxt;
      end
   end
   assign fault_mask = mask_r;
   assign alert = |(fault_src & ~mask_r); // [R14]

   // ******************************
   // monitor converter and averaging
   // ******************************
   logic vsm_d_r;
   cop_chan_t chan_r;
   logic [11:0] rb_w [3];
   logic [2:0] shift;
   wire vsm_chg = opt_r.vout_only_fast_mode != vsm_d_r;
   assign adc_run = opt_r.monitor_converter_on; // [R4]
   // depth code 00=16, 01=bypass, 10=8, 11=32
   always_comb begin
      case (opt_r.sample_average_depth) // [R11]
         2'h0: shift = 3'h4;
         2'h1: shift = 3'h0;
         2'h2: shift = 3'h3;
         default: shift = 3'h5;
      endcase
   end
   // channel sequence, held on voltage in fast mode
   always_ff @(posedge clk) begin
      if (rst) begin
         chan_r <= COP_CH_VOUT;
         vsm_d_r <= 1'b0;
      end else begin
         vsm_d_r <= opt_r.vout_only_fast_mode;
         if (opt_r.vout_only_fast_mode) begin
            chan_r <= COP_CH_VOUT; // [R6]
         end else if (sample_valid && adc_run) begin
            chan_r <= (chan_r == COP_CH_TEMP) ? COP_CH_VOUT : cop_chan_t'(chan_r + 2'h1);
         end
      end
   end
   assign adc_chan = chan_r;

   // one accumulator per readback
   for (genvar c = 0; c < 3; c++) begin : g_avg
      logic [16:0] acc_r;
      logic [5:0] cnt_r;
      logic [11:0] rb_r;
      wire take = sample_valid && adc_run && (sample_in.chan == cop_chan_t'(c))
                  && !(opt_r.vout_only_fast_mode && c != 0); // [R4] [R6]
      wire [16:0] sum = acc_r + 17'(sample_in.data);
      wire last = (cnt_r + 6'h1) >= (6'h1 << shift); // [R12]
      always_ff @(posedge clk) begin
         if (rst) begin
            acc_r <= '0;
            cnt_r <= '0;
            rb_r <= 12'h000;
         end else if (vsm_chg && c == 0) begin
            acc_r <= '0; // [R8]
            cnt_r <= '0;
         end else if (take) begin // [R5]
            acc_r <= last ? 17'h00000 : sum;
            cnt_r <= last ? 6'h00 : cnt_r + 6'h1;
            if (last) begin
               rb_r <= 12'(sum >> shift); // [R12]
            end
         end
      end
      // each readback kept in its own lane, one driver per element
      assign rb_w[c] = rb_r;
   end
   assign vout_rb = rb_w[0];
   assign iout_rb = rb_w[1];
   assign temp_rb = rb_w[2];

   // ******************************
   // assertions
   // ******************************
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_store;
      store_all |=> nvm_wr && (nvm_wdata == (16'($past(opt_r)) & ~`COP_OPT_VOLATILE_MASK));
   endproperty
   a_store: assert property (p_store) else $error("store image wrong"); // [R1]
   property p_neg;
      opt_r.neg_current_limit_off |-> !neg_limit_act;
   endproperty
   a_neg: assert property (p_neg) else $error("negative limit active"); // [R2]
   property p_pin;
      opt_r.reset_out_select ? (shared_status_pin == !reset_req)
                             : (shared_status_pin == power_good_flag);
   endproperty
   a_pin: assert property (p_pin) else $error("pin function wrong"); // [R3]
   property p_freeze;
      !adc_run |=> $stable(vout_rb) && $stable(iout_rb) && $stable(temp_rb);
   endproperty
   a_freeze: assert property (p_freeze) else $error("readback moved while off"); // [R5]
   property p_vsm;
      opt_r.vout_only_fast_mode && $past(opt_r.vout_only_fast_mode) |=> $stable(iout_rb) && $stable(temp_rb);
   endproperty
   a_vsm: assert property (p_vsm) else $error("current or temp updated in fast mode"); // [R6]
   property p_fixed;
      (16'(opt_r) & `COP_OPT_FIXED_MASK) == `COP_OPT_FIXED_VAL;
   endproperty
   a_fixed: assert property (p_fixed) else $error("reserved bits wrong"); // [R19]
   property p_load;
      $past(load_pend_r) |-> !opt_r.vout_only_fast_mode && !opt_r.write_check_override;
   endproperty
   a_load: assert property (p_load) else $error("volatile bits set after load"); // [R20]
   property p_ivd;
      opt_r.write_check_override |-> !invalid_write_flag;
   endproperty
   a_ivd: assert property (p_ivd) else $error("invalid flag under override"); // [R10]
   property p_ara;
      ara_done && opt_r.alert_auto_mask_on |=> (fault_mask & $past(fault_src)) == $past(fault_src);
   endproperty
   a_ara: assert property (p_ara) else $error("auto mask missed"); // [R13]
   property p_restore;
      margin_up_restore == (opt_r.margin_up_restore_sel ? 16'h000F : 16'h0009)
      && margin_down_restore == (opt_r.margin_down_restore_sel ? 16'hFFF1 : 16'hFFF7);
   endproperty
   a_restore: assert property (p_restore) else $error("margin restore wrong"); // [R17] [R18]
   c_store: cover property (store_all ##1 nvm_wr);
   c_ara: cover property (ara_done && opt_r.alert_auto_mask_on);
   c_vout: cover property (adc_run ##1 $changed(vout_rb));
endmodule

//--- verif/cop_host_model.sv
// host side model that issues commands on the options command port
`timescale 1ns/1ns
module cop_host_model (
   // clock
   input wire logic clk,
   // command port
   output logic [7:0] cmd_code,
   output logic cmd_wr,
   output logic [15:0] cmd_wdata
);
   // idle command port at time zero
   initial begin
      cmd_code = 8'h00;
      cmd_wr = 1'h0;
      cmd_wdata = 16'h0000;
   end
   // address a command without writing, for reads
   task automatic pick(input logic [7:0] c);
      cmd_code = c;
   endtask
   // one write held over exactly one taking edge
   task automatic write(input logic [7:0] c, input logic [15:0] d);
      cmd_code = c;
      cmd_wdata = d;
      cmd_wr = 1'h1;
      @(posedge clk);
      #1;
      cmd_wr = 1'h0;
      cmd_wdata = ~d; // released data does not keep its value
   endtask
endmodule

//--- verif/tb_converter_options_register.sv
// self-checking bench for the converter options register
`timescale 1ns/1ns
`include "cop_regs.svh"
module tb_converter_options_register;
   import cop_pkg::*;
   logic clk, rst, cmd_wr, cmd_hit, store_all, nvm_wr, sample_valid, adc_run, neg_limit_trip, neg_limit_act;
   logic power_good_flag, reset_req, shared_status_pin, chk_wr, chk_bad, chk_accept, invalid_write_flag;
   logic ara_done, host_mask_wr, alert, shutdown_evt, vout_restore;
   logic [7:0] cmd_code, fault_src, host_mask_data, fault_mask;
   logic [15:0] cmd_wdata, cmd_rdata, nvm_data, nvm_wdata, margin_down_restore, margin_up_restore, w, e;
   logic [11:0] vout_rb, iout_rb, temp_rb, v;
   logic [1:0] loop_scale, sense_div;
   cop_sample_t sample_in;
   cop_chan_t adc_chan;
   int num_errors = 0, n_checks = 0, n, s;
   cop_options uut (
      .clk(clk), .rst(rst),
      .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_hit(cmd_hit),
      .nvm_data(nvm_data), .store_all(store_all), .nvm_wr(nvm_wr), .nvm_wdata(nvm_wdata),
      .sample_valid(sample_valid), .sample_in(sample_in), .adc_run(adc_run), .adc_chan(adc_chan),
      .vout_rb(vout_rb), .iout_rb(iout_rb), .temp_rb(temp_rb),
      .neg_limit_trip(neg_limit_trip), .neg_limit_act(neg_limit_act), .power_good_flag(power_good_flag),
      .reset_req(reset_req), .shared_status_pin(shared_status_pin),
      .chk_wr(chk_wr), .chk_bad(chk_bad), .chk_accept(chk_accept), .invalid_write_flag(invalid_write_flag),
      .fault_src(fault_src), .ara_done(ara_done), .host_mask_wr(host_mask_wr), .host_mask_data(host_mask_data),
      .fault_mask(fault_mask), .alert(alert),
      .loop_scale(loop_scale), .sense_div(sense_div), .shutdown_evt(shutdown_evt), .vout_restore(vout_restore),
      .margin_down_restore(margin_down_restore), .margin_up_restore(margin_up_restore)
   );
   cop_host_model hm (
      .clk(clk),
      .cmd_code(cmd_code),
      .cmd_wr(cmd_wr),
      .cmd_wdata(cmd_wdata)
   );
   // ************************
   // helpers
   // ************************
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   task automatic tick(input int k = 1);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         num_errors++;
      end
   endtask
   function automatic logic [15:0] fix(input logic [15:0] x);
      return (x & ~`COP_OPT_FIXED_MASK) | `COP_OPT_FIXED_VAL;
   endfunction
   // one sample, valid left high for back to back use
   task automatic send(input cop_chan_t c, input logic [11:0] d);
      sample_valid = 1'h1;
      sample_in = '{c, d};
      tick();
   endtask
   task automatic results;
      if (num_errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #400000;
      num_errors++;
      results();
   end
   // ************************
   // tests
   // ************************
   initial begin
      {store_all, sample_valid, neg_limit_trip, power_good_flag, reset_req, chk_wr, chk_bad} = '0;
      {ara_done, host_mask_wr, shutdown_evt, fault_src, host_mask_data, loop_scale, sample_in} = '0;
      rst = 1'h1;
      void'($urandom(32'h7A55));
      nvm_data = 16'($urandom);
      tick(5);
      hm.pick(`COP_CMD_OPTIONS);
      tick();
      chk(cmd_rdata, `COP_OPT_RESET);
      rst = 1'h0;
      tick(2);
      chk(cmd_rdata, fix(nvm_data) & ~`COP_OPT_VOLATILE_MASK);
      for (int i = 0; i < 20; i++) begin
         w = 16'($urandom);
         {neg_limit_trip, power_good_flag, reset_req, chk_wr, chk_bad, shutdown_evt} = 6'($urandom);
         loop_scale = 2'($urandom_range(2));
         hm.write(`COP_CMD_OPTIONS, w);
         e = fix(w);
         chk(cmd_rdata, e);
         chk(cmd_hit, 1'h1);
         chk(neg_limit_act, neg_limit_trip & ~e[0]);
         chk(shared_status_pin, e[1] ? !reset_req : power_good_flag);
         chk(adc_run, e[2]);
         chk(chk_accept, e[4]);
         chk(invalid_write_flag, chk_wr & chk_bad & ~e[4]);
         chk(sense_div, e[9:8] != 2'h0 ? e[9:8] : 2'h3 - loop_scale);
         chk(vout_restore, shutdown_evt & e[11]);
         chk(margin_down_restore, e[13] ? `COP_MLO_RESTORE_1 : `COP_MLO_RESTORE_0);
         chk(margin_up_restore, e[14] ? `COP_MHI_RESTORE_1 : `COP_MHI_RESTORE_0);
         store_all = 1'h1;
         tick();
         store_all = 1'h0;
         chk(nvm_wr, 1'h1);
         chk(nvm_wdata, e & ~`COP_OPT_VOLATILE_MASK);
      end
      hm.pick(8'hE4);
      tick();
      chk(cmd_hit, 1'h0);
      chk(cmd_rdata, 16'h0000);
      // every averaging depth, accumulator cleared by a mode toggle first
      for (int d = 0; d < 4; d++) begin
         hm.write(`COP_CMD_OPTIONS, 16'h000C | 16'(d << 5));
         hm.write(`COP_CMD_OPTIONS, 16'h0004 | 16'(d << 5));
         // the edge after a mode change only clears the accumulator
         tick();
         n = d == 0 ? 16 : d == 1 ? 1 : d == 2 ? 8 : 32;
         s = 0;
         for (int k = 0; k < n; k++) begin
            v = 12'($urandom);
            s += v;
            send(COP_CH_VOUT, v);
         end
         sample_valid = 1'h0;
         tick(2);
         chk(vout_rb, 16'(s / n));
      end
      hm.write(`COP_CMD_OPTIONS, 16'h0024);
      send(COP_CH_IOUT, 12'hA5C);
      sample_valid = 1'h0;
      tick();
      chk(iout_rb, 16'hA5C);
      send(COP_CH_TEMP, 12'h5E1);
      sample_valid = 1'h0;
      tick();
      chk(temp_rb, 16'h05E1);
      hm.write(`COP_CMD_OPTIONS, 16'h002C);
      send(COP_CH_IOUT, 12'h123);
      send(COP_CH_TEMP, 12'h456);
      send(COP_CH_VOUT, 12'h3C7);
      sample_valid = 1'h0;
      tick();
      chk(iout_rb, 16'h0A5C);
      chk(temp_rb, 16'h05E1);
      chk(vout_rb, 16'h03C7);
      chk(adc_chan, 16'h0000);
      hm.write(`COP_CMD_OPTIONS, 16'h0020);
      send(COP_CH_VOUT, 12'h811);
      sample_valid = 1'h0;
      tick();
      chk(vout_rb, 16'h03C7);
      // alert response masking, on then off
      hm.write(`COP_CMD_OPTIONS, 16'h0080);
      fault_src = 8'($urandom) | 8'h01;
      tick();
      chk(alert, 1'h1);
      ara_done = 1'h1;
      tick();
      ara_done = 1'h0;
      chk({fault_mask, 7'h00, alert}, {fault_src, 8'h00});
      host_mask_wr = 1'h1;
      tick();
      host_mask_wr = 1'h0;
      hm.write(`COP_CMD_OPTIONS, 16'h0000);
      ara_done = 1'h1;
      tick();
      ara_done = 1'h0;
      chk({fault_mask, 7'h00, alert}, 16'h0001);
      results();
   end
endmodule
